// File: csl_car_logic.sv
// Per-car sprite, crash, skid, video level and speaker gating logic.
// Assumes all game inputs are synchronous to REF_CLK and that an APB
// master with 32-bit data loads the pattern store before play.
`timescale 1ns/100ps
`include "csl_regs.svh"

// Overview of operation
// - Pattern store address is rotation, three line bits, two upper column bits.
// - Low column bits pick one of eight pattern bits, true and complement.
// - Pixel selection is enabled only inside the car window.
// - Car window spans 16 pixel clocks and 8 lines from motion counters.
// - Selected pixel is registered before it becomes car video.
// - With collision high, vertical reset edges load first and sequence stages.
// - Collision low clears the first crash stage at once.
// - Crash pulse is low while first stage is clear and sequence high.
// - Crash pulse ends after the next vertical reset rising edge.
// - Crash pulse stops motion and fires the crunch sound one-shot.
// - Sequence stays low, blocking crashes, until the second vertical reset rise after contact ends.
// - Car video, sequence low and skid request rise start half-second skid.
// - Steering latch refuses new data while the skid pulse runs.
// - Skid pulse enables the tire screech sound.
// - Composite sync combines vertical and horizontal sync.
// - Grey level for second car, dark score, unlit flags or slicks.
// - White level for barrier, blinking lit flags, first car or bright score.
// - First speaker is silenced in attract mode.
// - Second speaker is silenced in attract mode and one-player games.
module csl_car_logic
    import csl_pkg::*;
#(
    parameter csl_count_t SKID_CYCLES   = 27'(`CSL_SKID_CYCLES),
    parameter csl_count_t CRUNCH_CYCLES = 27'(`CSL_CRUNCH_CYCLES)
) (
    input  wire logic          REF_CLK,
    input  wire logic          RST,
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire csl_apb_addr_t PADDR,
    input  wire csl_word_t     PWDATA,
    output csl_word_t          PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    input  wire logic [3:0]    ROTATION_CODE,
    input  wire logic [7:0]    H_MOTION,
    input  wire logic [7:0]    V_MOTION,
    input  wire logic          COLLIDE_N,
    input  wire logic          V_RESET,
    input  wire logic          SKID_REQ,
    input  wire logic [3:0]    STEER_DATA,
    input  wire logic          STEER_LOAD,
    input  wire logic          H_SYNC,
    input  wire logic          V_SYNC,
    input  wire logic          CAR2_VIDEO,
    input  wire logic          SCORE_DARK,
    input  wire logic          SCORE_BRIGHT,
    input  wire logic          FLAG_UNLIT,
    input  wire logic          FLAG_LIT,
    input  wire logic          OIL_SLICK,
    input  wire logic          BARRIER,
    input  wire logic          FRAME_BLINK_BIT,
    input  wire logic          ATTRACT,
    input  wire logic          ONE_PLAYER,
    input  wire logic          SPK1_SOUND,
    input  wire logic          SPK2_SOUND,
    output logic               CAR_VIDEO,
    output logic               CAR_VIDEO_N,
    output logic               CRASH_N,
    output logic               COLLISION_SEQUENCE,
    output logic               MOTION_STOP,
    output logic               CRUNCH_SOUND,
    output logic               SKID_ACTIVE,
    output logic               SCREECH_EN,
    output logic [3:0]         STEER_LATCHED,
    output logic               COMP_SYNC,
    output logic               GREY_LEVEL,
    output logic               WHITE_LEVEL,
    output logic               SPK1_OUT,
    output logic               SPK2_OUT
);
    import csl_pkg::*;

    // Pattern store, loaded by software, read by the video path.
    csl_byte_t     rom_mem [512];
    csl_rom_addr_t rom_addr_reg;
    csl_rom_addr_t rom_addr_next;
    logic [1:0]    ctrl_reg;
    logic [1:0]    ctrl_next;
    csl_word_t     prdata_reg;

    // Video path signals.
    logic [2:0]    line_index;
    logic [4:0]    column_index;
    logic          car_window;
    csl_rom_addr_t pix_addr;
    csl_byte_t     pix_byte;
    logic          pix_true;
    logic          car_video_reg;

    // Crash and skid signals.
    logic          vreset_d_reg;
    logic          vreset_rise;
    logic          stage1_reg;
    logic          stage1_next;
    logic          first_stage;
    logic          seq_reg;
    logic          seq_next;
    logic          crash_active;
    logic          crash_d_reg;
    logic          skid_req_d_reg;
    logic          skid_fire;
    logic [3:0]    steer_reg;

    // Registered video levels and sound gates.
    logic          sync_reg;
    logic          grey_reg;
    logic          white_reg;
    logic          spk1_reg;
    logic          spk2_reg;

    // APB decode.
    logic          apb_setup;
    logic          apb_access;
    logic          apb_wr;
    logic          hit_ctrl;
    logic          hit_status;
    logic          hit_addr;
    logic          hit_data;
    logic          hit_any;
    csl_word_t     status_word;
    csl_word_t     rdata_mux;

    csl_timer_if skid_if ();
    csl_timer_if crunch_if ();

    // Zero wait states keep the slave simple; every access ends at once.
    assign apb_setup  = PSEL && !PENABLE;
    assign apb_access = PSEL && PENABLE;
    assign apb_wr     = apb_access && PWRITE;
    assign hit_ctrl   = (PADDR == `CSL_OFF_CTRL);
    assign hit_status = (PADDR == `CSL_OFF_STATUS);
    assign hit_addr   = (PADDR == `CSL_OFF_ROM_ADDR);
    assign hit_data   = (PADDR == `CSL_OFF_ROM_DATA);
    assign hit_any    = hit_ctrl || hit_status || hit_addr || hit_data;
    assign PREADY     = 1'b1;
    assign PSLVERR    = apb_access && !hit_any;
    assign PRDATA     = prdata_reg;

    // Status shows the live crash, skid and window state.
    assign status_word = {26'h0000000,
                          car_window,
                          crunch_if.active,
                          skid_if.active,
                          crash_active,
                          seq_reg,
                          first_stage};

    // Read data selection; unmapped addresses read zero.
    assign rdata_mux = hit_ctrl   ? {30'h00000000, ctrl_reg} :
                       hit_status ? status_word :
                       hit_addr   ? {23'h000000, rom_addr_reg} :
                       hit_data   ? {24'h000000, rom_mem[rom_addr_reg]} :
                       32'h00000000;

    // A data access moves the load pointer so a block loads in sequence.
    assign ctrl_next = (apb_wr && hit_ctrl) ? PWDATA[1:0] : ctrl_reg;
    assign rom_addr_next = (apb_wr && hit_addr) ? PWDATA[8:0] :
                           (apb_access && hit_data) ?
                               rom_addr_reg + 9'h001 : rom_addr_reg;

    // Read data is captured in setup so it stands through access.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ctrl_reg     <= `CSL_CTRL_RESET;
            rom_addr_reg <= 9'h000;
            prdata_reg   <= 32'h00000000;
        end else begin
            ctrl_reg     <= ctrl_next;
            rom_addr_reg <= rom_addr_next;
            prdata_reg   <= apb_setup ? rdata_mux : prdata_reg;
        end
    end

    // Pattern store writes; storage carries no reset.
    always_ff @(posedge REF_CLK) begin
        if (apb_wr && hit_data) begin
            rom_mem[rom_addr_reg] <= PWDATA[7:0];
        end
    end

    assign line_index   = V_MOTION[2:0];
    assign column_index = H_MOTION[4:0];

    // window decode. Sixteen columns and eight lines match the top bits.
    assign car_window = (H_MOTION[7:4] == `CSL_WIN_H_MATCH) &&
                        (V_MOTION[7:3] == `CSL_WIN_V_MATCH);

    // pattern addressing. Rotation selects the image, line and column
    // pick the byte.
    assign pix_addr = {ROTATION_CODE, line_index, column_index[4:3]};
    assign pix_byte = rom_mem[pix_addr];

    // serial bit select. Column zero shows the most significant bit.
    assign pix_true = car_window && ctrl_reg[`CSL_CTRL_VIDEO_EN] &&
                      pix_byte[3'h7 - column_index[2:0]];

    // pixel register. The flop strips decode glitches from the output.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            car_video_reg <= 1'b0;
        end else begin
            car_video_reg <= pix_true;
        end
    end

    assign CAR_VIDEO   = car_video_reg;
    assign CAR_VIDEO_N = !car_video_reg;

    // Vertical reset is sampled, so its rising edge is one clock wide.
    assign vreset_rise = V_RESET && !vreset_d_reg;

    // contact clear. The stage reads as clear in the same cycle that
    // the collision input drops, not one clock later.
    assign first_stage = stage1_reg && COLLIDE_N;

    // stage loading. The first stage captures a one, the sequence
    // stage follows it on each vertical reset rise.
    assign stage1_next = !COLLIDE_N ? 1'b0 :
                         vreset_rise ? 1'b1 : stage1_reg;
    // pulse ending. The cleared first stage is copied into sequence.
    // sequence hold. It stays low while contact lasts.
    assign seq_next = vreset_rise ? first_stage : seq_reg;

    assign crash_active = !first_stage && seq_reg;

    // Crash stages and edge memories.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            vreset_d_reg   <= 1'b0;
            stage1_reg     <= 1'b0;
            seq_reg        <= 1'b0;
            crash_d_reg    <= 1'b0;
            skid_req_d_reg <= 1'b0;
        end else begin
            vreset_d_reg   <= V_RESET;
            stage1_reg     <= stage1_next;
            seq_reg        <= seq_next;
            crash_d_reg    <= crash_active;
            skid_req_d_reg <= SKID_REQ;
        end
    end

    assign CRASH_N            = !crash_active;
    assign COLLISION_SEQUENCE = seq_reg;

    // motion stop follows the whole pulse; crunch triggers on its leading edge.
    assign MOTION_STOP       = crash_active;
    assign crunch_if.trigger = crash_active && !crash_d_reg;
    assign CRUNCH_SOUND      = crunch_if.active;

    csl_pulse_timer #(
        .LEN (CRUNCH_CYCLES)
    ) u_crunch (
        .clk (REF_CLK),
        .rst (RST),
        .tif (crunch_if)
    );

    // skid trigger. Only fires while the sequence stage is low, as after a crash.
    assign skid_fire = car_video_reg && !seq_reg &&
                       SKID_REQ && !skid_req_d_reg;
    assign skid_if.trigger = skid_fire;

    csl_pulse_timer #(
        .LEN (SKID_CYCLES)
    ) u_skid (
        .clk (REF_CLK),
        .rst (RST),
        .tif (skid_if)
    );

    assign SKID_ACTIVE = skid_if.active;
    // screech enable follows the skid pulse.
    assign SCREECH_EN  = skid_if.active;

    // steering latch freeze. Loads are dropped, not queued.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            steer_reg <= 4'h0;
        end else if (STEER_LOAD && !skid_if.active) begin
            steer_reg <= STEER_DATA;
        end
    end

    assign STEER_LATCHED = steer_reg;

    // Video levels and speaker gates, registered for clean outputs.
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sync_reg  <= 1'b0;
            grey_reg  <= 1'b0;
            white_reg <= 1'b0;
            spk1_reg  <= 1'b0;
            spk2_reg  <= 1'b0;
        end else begin
            sync_reg  <= H_SYNC || V_SYNC;
            grey_reg  <= CAR2_VIDEO || SCORE_DARK || FLAG_UNLIT ||
                         OIL_SLICK;
            white_reg <= BARRIER || (FLAG_LIT && FRAME_BLINK_BIT) ||
                         car_video_reg || SCORE_BRIGHT;
            spk1_reg  <= SPK1_SOUND && !ATTRACT &&
                         ctrl_reg[`CSL_CTRL_SOUND_EN];
            spk2_reg  <= SPK2_SOUND && !ATTRACT && !ONE_PLAYER &&
                         ctrl_reg[`CSL_CTRL_SOUND_EN];
        end
    end

    assign COMP_SYNC   = sync_reg;
    assign GREY_LEVEL  = grey_reg;
    assign WHITE_LEVEL = white_reg;
    assign SPK1_OUT    = spk1_reg;
    assign SPK2_OUT    = spk2_reg;
endmodule : csl_car_logic

// File: csl_car_logic_assertions.sv
// Concurrent checks on the car logic top ports.
// Assumes one clock domain and the port names of csl_car_logic.
`timescale 1ns/100ps
module csl_car_logic_assertions (
    input wire logic       REF_CLK,
    input wire logic       RST,
    input wire logic [7:0] H_MOTION,
    input wire logic [7:0] V_MOTION,
    input wire logic       COLLIDE_N,
    input wire logic       V_RESET,
    input wire logic       STEER_LOAD,
    input wire logic       H_SYNC,
    input wire logic       V_SYNC,
    input wire logic       CAR_VIDEO,
    input wire logic       CAR_VIDEO_N,
    input wire logic       CRASH_N,
    input wire logic       COLLISION_SEQUENCE,
    input wire logic       MOTION_STOP,
    input wire logic       CRUNCH_SOUND,
    input wire logic       SKID_ACTIVE,
    input wire logic       SCREECH_EN,
    input wire logic [3:0] STEER_LATCHED,
    input wire logic       COMP_SYNC
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);
    // A vertical reset rise is a high sample after a low one.
    sequence vres_rise_s;
        V_RESET && !$past(V_RESET);
    endsequence
    sequence outside_s;
        !(H_MOTION[7:4] == 4'hF && V_MOTION[7:3] == 5'h1F);
    endsequence
    // Each check ties an output to its cause with the exact delay.
    pix_pair_a: assert property (CAR_VIDEO_N != CAR_VIDEO)
        else $error("car video pair not complementary");
    win_gate_a: assert property (outside_s |=> !CAR_VIDEO)
        else $error("car pixel outside window");
    crash_low_a: assert property (
        COLLISION_SEQUENCE && !COLLIDE_N |-> !CRASH_N)
        else $error("crash pulse missing on contact");
    motion_stop_a: assert property (!CRASH_N |-> MOTION_STOP)
        else $error("motion not stopped in crash");
    crunch_start_a: assert property ($fell(CRASH_N) |=> CRUNCH_SOUND)
        else $error("crunch sound not started");
    crash_end_a: assert property (
        vres_rise_s ##0 !CRASH_N |=> CRASH_N)
        else $error("crash pulse not ended by vertical reset");
    seq_block_a: assert property (
        !COLLISION_SEQUENCE && !COLLIDE_N |=> !COLLISION_SEQUENCE)
        else $error("sequence stage set during contact");
    latch_hold_a: assert property (
        SKID_ACTIVE && STEER_LOAD |=> $stable(STEER_LATCHED))
        else $error("steering latch took data in skid");
    screech_follow_a: assert property (SCREECH_EN == SKID_ACTIVE)
        else $error("screech does not follow skid");
    comp_sync_a: assert property (
        1'b1 |=> COMP_SYNC == $past(H_SYNC || V_SYNC))
        else $error("composite sync wrong");
endmodule : csl_car_logic_assertions

bind csl_car_logic csl_car_logic_assertions chk_u (
    .REF_CLK, .RST, .H_MOTION, .V_MOTION, .COLLIDE_N, .V_RESET,
    .STEER_LOAD, .H_SYNC, .V_SYNC, .CAR_VIDEO, .CAR_VIDEO_N, .CRASH_N,
    .COLLISION_SEQUENCE, .MOTION_STOP, .CRUNCH_SOUND, .SKID_ACTIVE,
    .SCREECH_EN, .STEER_LATCHED, .COMP_SYNC
);

// File: csl_far_model.sv
// Vertical reset source standing in for the far side's sync chain.
// Assumes the bench clock and an active-high asynchronous reset.
`timescale 1ns/100ps
module csl_far_model (
    input  wire logic clk,
    input  wire logic rst,
    output logic      v_reset
);
    logic [2:0] cnt_reg;
    // A short eight-cycle frame keeps crash tests quick.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
        end
    end
    assign v_reset = cnt_reg[2] & cnt_reg[1];
endmodule : csl_far_model

// File: csl_pkg.sv
// Types shared by the car sprite and collision logic.
// Assumes nothing of its surroundings.
package csl_pkg;
    typedef logic [8:0]  csl_rom_addr_t;
    typedef logic [7:0]  csl_byte_t;
    typedef logic [26:0] csl_count_t;
    typedef logic [7:0]  csl_apb_addr_t;
    typedef logic [31:0] csl_word_t;
endpackage : csl_pkg

// File: csl_pulse_timer.sv
// Non-retriggerable one-shot with a length given in clock cycles.
// Assumes the trigger is a one-cycle pulse synchronous to the clock.
`timescale 1ns/100ps
module csl_pulse_timer
    import csl_pkg::*;
#(
    parameter csl_count_t LEN = 27'd1
) (
    input  wire logic   clk,
    input  wire logic   rst,
    csl_timer_if.timer  tif
);
    import csl_pkg::*;

    csl_count_t cnt_reg;
    csl_count_t cnt_next;

    // A trigger while running is ignored, like a monostable timer.
    assign cnt_next = (tif.trigger && cnt_reg == '0) ? LEN :
                      (cnt_reg != '0) ? cnt_reg - 27'd1 : cnt_reg;
    assign tif.active = (cnt_reg != '0);

    // Counter holds the remaining pulse length.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule : csl_pulse_timer

// File: csl_regs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes a 32-bit APB bus with byte addresses in the low eight bits.
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH

`define CSL_OFF_CTRL        8'h00
`define CSL_OFF_STATUS      8'h04
`define CSL_OFF_ROM_ADDR    8'h08
`define CSL_OFF_ROM_DATA    8'h0C

`define CSL_CTRL_VIDEO_EN   0
`define CSL_CTRL_SOUND_EN   1
`define CSL_CTRL_RESET      2'h3

`define CSL_ST_FIRST        0
`define CSL_ST_SEQ          1
`define CSL_ST_CRASH        2
`define CSL_ST_SKID         3
`define CSL_ST_CRUNCH       4
`define CSL_ST_WINDOW       5

`define CSL_WIN_H_MATCH     4'hF
`define CSL_WIN_V_MATCH     5'h1F

`define CSL_CLK_MHZ         250
`define CSL_SKID_TIME_MS    500
`define CSL_SKID_CYCLES     (`CSL_SKID_TIME_MS * `CSL_CLK_MHZ * 1000)
`define CSL_CRUNCH_TIME_MS  250
`define CSL_CRUNCH_CYCLES   (`CSL_CRUNCH_TIME_MS * `CSL_CLK_MHZ * 1000)

`endif

// File: csl_timer_if.sv
// Trigger and activity pair between the top module and a one-shot.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface csl_timer_if;
    logic trigger;
    logic active;
    modport timer (input trigger, output active);
    modport user  (output trigger, input active);
endinterface : csl_timer_if

// File: tb_csl_car_logic.sv
// Self-checking bench for the car sprite and collision logic.
// Assumes csl_far_model supplies vertical reset pulses.
`timescale 1ns/100ps
module tb_csl_car_logic;
    import csl_pkg::*;
    logic REF_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, e;
    csl_apb_addr_t PADDR;
    csl_word_t PWDATA, PRDATA, q;
    logic [3:0] ROTATION_CODE, STEER_DATA, STEER_LATCHED;
    logic [7:0] H_MOTION, V_MOTION, h, vv;
    logic COLLIDE_N, V_RESET, SKID_REQ, STEER_LOAD, H_SYNC, V_SYNC;
    logic CAR2_VIDEO, SCORE_DARK, SCORE_BRIGHT, FLAG_UNLIT, FLAG_LIT;
    logic OIL_SLICK, BARRIER, FRAME_BLINK_BIT, ATTRACT, ONE_PLAYER;
    logic SPK1_SOUND, SPK2_SOUND, CAR_VIDEO, CAR_VIDEO_N, CRASH_N;
    logic COLLISION_SEQUENCE, MOTION_STOP, CRUNCH_SOUND, SKID_ACTIVE;
    logic SCREECH_EN, COMP_SYNC, GREY_LEVEL, WHITE_LEVEL, SPK1_OUT;
    logic SPK2_OUT, ec, eg, ew, es, e1, e2;
    int bad_count, check_count, n, c, v, r;
    csl_byte_t rom [512];

    csl_car_logic #(.SKID_CYCLES(27'h14), .CRUNCH_CYCLES(27'hA)) dut_u (
        .REF_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .ROTATION_CODE, .H_MOTION, .V_MOTION,
        .COLLIDE_N, .V_RESET, .SKID_REQ, .STEER_DATA, .STEER_LOAD, .H_SYNC,
        .V_SYNC, .CAR2_VIDEO, .SCORE_DARK, .SCORE_BRIGHT, .FLAG_UNLIT,
        .FLAG_LIT, .OIL_SLICK, .BARRIER, .FRAME_BLINK_BIT, .ATTRACT,
        .ONE_PLAYER, .SPK1_SOUND, .SPK2_SOUND, .CAR_VIDEO, .CAR_VIDEO_N,
        .CRASH_N, .COLLISION_SEQUENCE, .MOTION_STOP, .CRUNCH_SOUND,
        .SKID_ACTIVE, .SCREECH_EN, .STEER_LATCHED, .COMP_SYNC, .GREY_LEVEL,
        .WHITE_LEVEL, .SPK1_OUT, .SPK2_OUT);
    csl_far_model far_u (.clk(REF_CLK), .rst(RST), .v_reset(V_RESET));

    // Free-running 250 MHz clock.
    initial begin
        REF_CLK = 1'b0;
        forever #2 REF_CLK = ~REF_CLK;
    end

    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask : chk

    // One APB transfer; waits on PREADY instead of assuming a latency.
    // Only the watchdog ends a wait that never sees PREADY.
    task apb(input logic w, input csl_apb_addr_t a, input csl_word_t d);
        @(posedge REF_CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, a, d};
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do @(posedge REF_CLK); while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        {PSEL, PENABLE} <= 2'h0;
    endtask : apb

    task finish_test;
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // Watchdog sized well past the expected run of some 2200 cycles.
    initial begin
        #100000;
        bad_count++;
        finish_test;
    end

    // Main sequence: registers, pattern store, video, crash, skid.
    initial begin
        {PSEL, PENABLE, PWRITE, SKID_REQ, STEER_LOAD, H_SYNC, V_SYNC,
         CAR2_VIDEO, SCORE_DARK, SCORE_BRIGHT, FLAG_UNLIT, FLAG_LIT,
         OIL_SLICK, BARRIER, FRAME_BLINK_BIT, ATTRACT, ONE_PLAYER,
         SPK1_SOUND, SPK2_SOUND, ROTATION_CODE, H_MOTION, V_MOTION,
         STEER_DATA, PADDR, PWDATA} = '0;
        COLLIDE_N = 1'b1;
        RST = 1'b1;
        r = $urandom(94661);
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        apb(0, 8'h00, 0);
        chk("ctrl", q, 32'h3);
        chk("slverr ok", e, 0);
        chk("ready", PREADY, 1);
        apb(0, 8'h10, 0);
        chk("slverr", e, 1);
        chk("unmapped", q, 0);
        apb(1, 8'h08, 0);
        for (n = 0; n < 512; n++) begin
            rom[n] = (n == 2) ? 8'hFF : 8'($urandom);
            apb(1, 8'h0C, 32'(rom[n]));
        end
        apb(1, 8'h08, 32'h5);
        apb(0, 8'h0C, 0);
        chk("rom", q, rom[5]);
        for (c = 0; c < 4; c++) begin
            apb(1, 8'h00, c);
            for (v = 0; v < 150; v++) begin
                @(posedge REF_CLK);
                h = 8'($urandom);
                vv = 8'($urandom);
                r = $urandom;
                if (r[20]) h[7:4] = 4'hF;
                if (r[21]) vv[7:3] = 5'h1F;
                {H_MOTION, V_MOTION, ROTATION_CODE} <= {h, vv, r[3:0]};
                {H_SYNC, V_SYNC, CAR2_VIDEO, SCORE_DARK, SCORE_BRIGHT,
                 FLAG_UNLIT, FLAG_LIT, OIL_SLICK, BARRIER, FRAME_BLINK_BIT,
                 ATTRACT, ONE_PLAYER, SPK1_SOUND, SPK2_SOUND}
                    <= 14'(r[17:4] & $urandom);
                #1;
                if (v > 0) begin
                    chk("car", CAR_VIDEO, ec);
                    chk("car_n", CAR_VIDEO_N, !ec);
                    chk("grey", GREY_LEVEL, eg);
                    chk("sync", COMP_SYNC, es);
                    chk("spk1", SPK1_OUT, e1);
                    chk("spk2", SPK2_OUT, e2);
                end
                if (v > 1) chk("white", WHITE_LEVEL, ew);
                ew = BARRIER | (FLAG_LIT & FRAME_BLINK_BIT) | SCORE_BRIGHT | ec;
                ec = (h[7:4] == 4'hF && vv[7:3] == 5'h1F && c[0]) ?
                    rom[{r[3:0], vv[2:0], h[4:3]}][~h[2:0]] : 1'b0;
                eg = CAR2_VIDEO | SCORE_DARK | FLAG_UNLIT | OIL_SLICK;
                es = H_SYNC | V_SYNC;
                e1 = SPK1_SOUND & !ATTRACT & c[1];
                e2 = SPK2_SOUND & !ATTRACT & !ONE_PLAYER & c[1];
            end
        end
        // Park the car on a fully lit pattern row inside its window.
        @(posedge REF_CLK);
        {H_MOTION, V_MOTION, ROTATION_CODE} <= {8'hF0, 8'hF8, 4'h0};
        n = 0;
        do begin @(posedge REF_CLK); #1; end
            while (COLLISION_SEQUENCE !== 1'b1 && ++n < 40);
        chk("seq set", COLLISION_SEQUENCE, 1);
        chk("crash idle", CRASH_N, 1);
        @(posedge REF_CLK);
        COLLIDE_N <= 1'b0;
        #1 chk("crash", CRASH_N, 0);
        chk("stop", MOTION_STOP, 1);
        @(posedge REF_CLK);
        #1 chk("crunch", CRUNCH_SOUND, 1);
        n = 0;
        do begin @(posedge REF_CLK); #1; end
            while (CRASH_N !== 1'b1 && ++n < 20);
        chk("crash end", CRASH_N, 1);
        chk("seq clr", COLLISION_SEQUENCE, 0);
        repeat (20) @(posedge REF_CLK);
        #1 chk("no recrash", CRASH_N, 1);
        chk("seq held", COLLISION_SEQUENCE, 0);
        chk("car on", CAR_VIDEO, 1);
        @(posedge REF_CLK);
        SKID_REQ <= 1'b1;
        n = 0;
        do begin @(posedge REF_CLK); #1; end
            while (SKID_ACTIVE !== 1'b1 && ++n < 5);
        chk("skid on", SKID_ACTIVE, 1);
        // Request edges inside the pulse must not stretch it; the request
        // is left low at the end so no fresh pulse starts afterwards.
        n = 0;
        while (SKID_ACTIVE === 1'b1 && n < 40) begin
            n++;
            chk("screech", SCREECH_EN, 1);
            @(posedge REF_CLK);
            SKID_REQ <= ~SKID_REQ & (n < 20);
            STEER_LOAD <= 1'b1;
            STEER_DATA <= 4'($urandom | 1);
            #1;
        end
        chk("skid len", n, 20);
        chk("latch held", STEER_LATCHED, 0);
        @(posedge REF_CLK);
        STEER_DATA <= 4'hA;
        @(posedge REF_CLK);
        #1 chk("latch", STEER_LATCHED, 4'hA);
        finish_test;
    end
endmodule : tb_csl_car_logic
